// >>> core/ddr4_ctl_end.sv
// Controller end: APB-programmed power-up and warm-reset initialisation
`timescale 1ns/1ps
module ddr4_ctl_end import ddr4_init_pkg::*; #(
	parameter int RESET_COLD_CYC_P = RESET_COLD_CYC,
	parameter int INIT_WAIT_CYC_P = INIT_WAIT_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic init_done,
	ddr4_link_if.ctl link
);
	typedef enum logic [3:0] {S_IDLE, S_RST, S_PRECKE, S_TXPR, S_MRS, S_MRWAIT, S_ZQ, S_ZQWAIT,
		S_DONE} ctl_state_t;
	ctl_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [2:0] step_r;
	logic [$clog2(CK_HALF)-1:0] div_r;
	logic ck_r;
	logic odt_en_r;
	logic [A_W-1:0] mr_r [NUM_MR];
	logic reset_n_r;
	logic cke_r;
	logic odt_r;
	logic cs_n_r;
	logic [3:0] cmd_r;
	logic bg_r;
	logic [1:0] ba_r;
	logic [A_W-1:0] addr_r;
	logic cte_r;

	// APB decode
	wire setup = psel & ~penable;
	wire wr_acc = psel & penable & pready & pwrite;
	wire hit_ctrl = (paddr == REG_CTRL);
	wire hit_stat = (paddr == REG_STATUS);
	wire [7:0] mr_off = paddr - REG_MR_BASE;
	wire hit_mr = (paddr >= REG_MR_BASE) && (mr_off[7:2] < 6'(NUM_MR)) && (mr_off[1:0] == 2'h0);
	wire [2:0] mr_idx = mr_off[4:2];
	wire busy = (state_r != S_IDLE) && (state_r != S_DONE);
	wire [31:0] rd_val = hit_ctrl ? {29'h0, odt_en_r, 2'h0} :
		hit_stat ? {26'h0, 4'(state_r), init_done, busy} :
		hit_mr ? {18'h0, mr_r[mr_idx]} : 32'h0;
	wire go_cold = wr_acc & hit_ctrl & pwdata[CTRL_COLD];
	wire go_warm = wr_acc & hit_ctrl & pwdata[CTRL_WARM] & ~pwdata[CTRL_COLD];
	// Link clock divider; commands change on the falling edge
	wire div_wrap = (div_r == ($clog2(CK_HALF))'(CK_HALF - 1));
	wire fall_tick = div_wrap & ck_r;
	wire [2:0] cur_mr = MR_ORDER[step_r];

	assign link.reset_n = reset_n_r;
	assign link.cke = cke_r;
	assign link.ck = ck_r;
	assign link.odt = odt_r;
	assign link.cs_n = cs_n_r;
	assign link.act_n = cmd_r[3];
	assign link.ras_n = cmd_r[2];
	assign link.cas_n = cmd_r[1];
	assign link.we_n = cmd_r[0];
	assign link.bg = bg_r;
	assign link.ba = ba_r;
	assign link.addr = addr_r;
	assign link.connectivity_test_enable = cte_r;

	// Zero-wait APB slave, read data captured in setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~(hit_ctrl | hit_stat | hit_mr);
			if (setup)
				prdata <= pwrite ? 32'h0 : rd_val;
		end
	end

	// Software settings; mode values frozen while busy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			odt_en_r <= 1'b0;
			for (int i = 0; i < NUM_MR; i++)
				mr_r[i] <= MR_DEFAULT;
		end
		else if (wr_acc && hit_ctrl)
			odt_en_r <= pwdata[CTRL_ODT];
		else if (wr_acc && hit_mr && !busy)
			mr_r[mr_idx] <= pwdata[A_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_r <= '0;
			ck_r <= 1'b0;
		end
		else
		begin
			div_r <= div_wrap ? '0 : div_r + 1'b1;
			if (div_wrap)
				ck_r <= ~ck_r;
		end
	end

	// Initialisation sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= S_IDLE;
			cnt_r <= '0;
			step_r <= '0;
			reset_n_r <= 1'b0;
			cke_r <= 1'b0;
			odt_r <= 1'b0;
			cs_n_r <= 1'b1;
			cmd_r <= 4'hF;
			bg_r <= 1'b0;
			ba_r <= 2'h0;
			addr_r <= '0;
			cte_r <= 1'b0;
			init_done <= 1'b0;
		end
		else if (go_cold || go_warm)
		begin
			// A new reset may cut any step short
			reset_n_r <= 1'b0;
			cke_r <= 1'b0;
			odt_r <= 1'b0;
			cs_n_r <= 1'b1;
			init_done <= 1'b0;
			cnt_r <= go_cold ? CNT_W'(RESET_COLD_CYC_P - 1) : CNT_W'(RESET_WARM_CYC - 1);
			state_r <= S_RST;
		end
		else
		begin
			case (state_r)
				S_IDLE:
					state_r <= S_IDLE;
				S_RST:
					// Hold always exceeds the CKE setup, so CKE is low long enough
					if (cnt_r == '0 && RESET_WARM_CYC >= CKE_SETUP_CYC)
					begin
						reset_n_r <= 1'b1;
						cnt_r <= CNT_W'(INIT_WAIT_CYC_P - 1);
						state_r <= S_PRECKE;
					end
					else if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
				S_PRECKE:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else if (fall_tick)
					begin
						cke_r <= 1'b1;
						cs_n_r <= 1'b1;
						odt_r <= 1'b0;
						cnt_r <= CNT_W'(T_XPR_CK - 1);
						state_r <= S_TXPR;
					end
				S_TXPR:
					if (fall_tick)
					begin
						cnt_r <= cnt_r - 1'b1;
						if (cnt_r == CNT_W'(1))
						begin
							step_r <= '0;
							state_r <= S_MRS;
						end
					end
				S_MRS:
					if (fall_tick)
					begin
						cs_n_r <= 1'b0;
						cmd_r <= CMD_MRS;
						{bg_r, ba_r} <= cur_mr;
						addr_r <= mr_r[cur_mr];
						cnt_r <= (step_r == MR_LAST_STEP) ? CNT_W'(T_MOD_CK - 1) : CNT_W'(T_MRD_CK - 1);
						state_r <= S_MRWAIT;
					end
				S_MRWAIT:
					if (fall_tick)
					begin
						cs_n_r <= 1'b1;
						cmd_r <= 4'hF;
						cnt_r <= cnt_r - 1'b1;
						if (cnt_r == CNT_W'(1))
						begin
							step_r <= step_r + 1'b1;
							state_r <= (step_r == MR_LAST_STEP) ? S_ZQ : S_MRS;
						end
					end
				S_ZQ:
					if (fall_tick)
					begin
						cs_n_r <= 1'b0;
						cmd_r <= CMD_ZQ;
						{bg_r, ba_r} <= 3'h0;
						addr_r <= A_W'(1) << AP_BIT;
						cnt_r <= CNT_W'(T_ZQDLL_CK - 1);
						state_r <= S_ZQWAIT;
					end
				S_ZQWAIT:
					if (fall_tick)
					begin
						cs_n_r <= 1'b1;
						cmd_r <= 4'hF;
						cnt_r <= cnt_r - 1'b1;
						if (cnt_r == CNT_W'(1))
						begin
							init_done <= 1'b1;
							state_r <= S_DONE;
						end
					end
				S_DONE:
					// ODT only follows software once init is over
					odt_r <= odt_en_r;
				default:
					state_r <= S_IDLE;
			endcase
		end
	end
endmodule

// >>> core/ddr4_init_pkg.sv
// Shared constants for the DDR4 reset and initialisation link
package ddr4_init_pkg;
	localparam int CLK_PERIOD_PS = 40000;
	localparam int T_RESET_COLD_NS = 200000;
	localparam int T_RESET_WARM_NS = 100;
	localparam int T_CKE_SETUP_NS = 10;
	localparam int T_INIT_NS = 500000;
	// Least times round up, never below one cycle
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RESET_COLD_CYC = ns_to_cyc(T_RESET_COLD_NS);
	localparam int RESET_WARM_CYC = ns_to_cyc(T_RESET_WARM_NS);
	localparam int CKE_SETUP_CYC = ns_to_cyc(T_CKE_SETUP_NS);
	localparam int INIT_WAIT_CYC = ns_to_cyc(T_INIT_NS);
	// Link clock: pclk cycles per half period, 320 ns period
	localparam int CK_HALF = 4;
	// Waits in link clock periods; each must be at least 2
	localparam int T_XPR_CK = 5;
	localparam int T_MRD_CK = 8;
	localparam int T_MOD_CK = 24;
	localparam int T_DLLK_CK = 512;
	localparam int T_ZQINIT_CK = 1024;
	localparam int T_ZQDLL_CK = (T_DLLK_CK > T_ZQINIT_CK) ? T_DLLK_CK : T_ZQINIT_CK;
	localparam int CNT_W = 16;
	localparam int A_W = 14;
	localparam int ROW_W = 15;
	localparam int COL_W = 10;
	localparam int NUM_MR = 7;
	localparam int NUM_BANK = 8;
	localparam logic [2:0] MR_ORDER [NUM_MR] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
	localparam logic [2:0] MR_LAST_STEP = 3'h6;
	// Reset value of every mode register; all defaulted fields read 0
	localparam logic [A_W-1:0] MR_DEFAULT = 14'h0000;
	localparam int MR3_GEARDOWN_BIT = 3;
	localparam int MR3_PDA_BIT = 4;
	localparam int MR4_MPS_BIT = 1;
	localparam int MR4_CAL_LSB = 6;
	localparam int MR5_PAR_LSB = 0;
	localparam int MR1_RTT_LSB = 8;
	localparam int MR0_BL_LSB = 0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_BC4 = 2'h2;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam logic [3:0] BL8_BEATS = 4'h8;
	localparam logic [3:0] BC4_BEATS = 4'h4;
	// Command codes on {act_n, ras_n, cas_n, we_n} with cs_n low
	localparam logic [3:0] CMD_MRS = 4'h8;
	localparam logic [3:0] CMD_ZQ = 4'hE;
	localparam logic [3:0] CMD_RD = 4'hD;
	localparam logic [3:0] CMD_WR = 4'hC;
	// APB register map of the controller
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MR_BASE = 8'h10;
	localparam int CTRL_COLD = 0;
	localparam int CTRL_WARM = 1;
	localparam int CTRL_ODT = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
endpackage

// >>> core/ddr4_link_if.sv
// Link between the memory controller and the DRAM
`timescale 1ns/1ps
interface ddr4_link_if;
	import ddr4_init_pkg::*;
	logic reset_n;
	logic cke;
	logic ck;
	logic odt;
	logic cs_n;
	logic act_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic bg;
	logic [1:0] ba;
	logic [A_W-1:0] addr;
	logic connectivity_test_enable;
	modport ctl (output reset_n, cke, ck, odt, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr,
		connectivity_test_enable);
	modport dev (input reset_n, cke, ck, odt, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr,
		connectivity_test_enable);
endinterface

// >>> core/link_sync.sv
// Two-flop synchroniser for a bundle of link inputs
`timescale 1ns/1ps
module link_sync #(
	parameter int W = 1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// >>> core/ddr4_dev_end.sv
// DRAM end: reset defaults, termination state, mode loads and access decode
`timescale 1ns/1ps
module ddr4_dev_end import ddr4_init_pkg::*; #(
	parameter int INIT_WAIT_CYC_P = INIT_WAIT_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	ddr4_link_if.dev link,
	output logic term_hiz,
	output logic term_on,
	output logic ready,
	output logic gear_down_quarter,
	output logic pda_enable,
	output logic max_power_save,
	output logic cs_latency_on,
	output logic parity_latency_on,
	output logic acc_valid,
	output logic acc_write,
	output logic acc_auto_pre,
	output logic [3:0] acc_beats,
	output logic act_valid,
	output logic act_bank_group,
	output logic [1:0] act_bank,
	output logic [ROW_W-1:0] act_row,
	output logic [COL_W-1:0] acc_col,
	output logic [NUM_BANK-1:0] open_banks
);
	typedef enum logic [2:0] {D_RESET, D_PRE, D_INIT, D_ZQ, D_READY} dev_state_t;
	// Nine single pins, bank group, two bank bits, then the address
	localparam int SW = 12 + A_W;
	dev_state_t state_r;
	logic [SW-1:0] s;
	logic ck_q_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] icnt_r;
	logic [A_W-1:0] mr_r [NUM_MR];

	link_sync #(.W(SW)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({link.reset_n, link.cke, link.ck, link.odt, link.cs_n, link.act_n, link.ras_n,
			link.cas_n, link.we_n, link.bg, link.ba, link.addr}),
		.q(s)
	);

	// Named views of the synchronised link
	wire rst_n_s = s[SW-1];
	wire cke_s = s[SW-2];
	wire ck_s = s[SW-3];
	wire odt_s = s[SW-4];
	wire cs_n_s = s[SW-5];
	wire [3:0] cmd_s = s[SW-6 -: 4];
	wire bg_s = s[A_W+2];
	wire [1:0] ba_s = s[A_W+1 -: 2];
	wire [A_W-1:0] addr_s = s[A_W-1:0];
	wire ck_rise = ck_s & ~ck_q_r;
	wire cmd_take = ck_rise & ~cs_n_s;
	wire [2:0] mr_sel = {bg_s, ba_s};
	wire [2:0] bank_idx = {bg_s, ba_s};
	wire [2:0] nominal_termination_setting = mr_r[1][MR1_RTT_LSB +: 3];
	wire [1:0] bl_mode = mr_r[0][MR0_BL_LSB +: 2];
	// Eight pin beats per 8n core word, two per clock
	wire [3:0] beats = (bl_mode == BL_BC4) ? BC4_BEATS :
		(bl_mode == BL_OTF && !addr_s[BC_BIT]) ? BC4_BEATS : BL8_BEATS;
	wire is_rdwr = (cmd_s == CMD_RD) || (cmd_s == CMD_WR);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ck_q_r <= 1'b0;
		else
			ck_q_r <= ck_s;
	end

	// Mode register images; defaults restored on every reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_MR; i++)
				mr_r[i] <= MR_DEFAULT;
		end
		else if (!rst_n_s)
		begin
			for (int i = 0; i < NUM_MR; i++)
				mr_r[i] <= MR_DEFAULT;
		end
		else if (cmd_take && cmd_s == CMD_MRS && (state_r == D_INIT || state_r == D_READY)
			&& mr_sel < 3'(NUM_MR))
			mr_r[mr_sel] <= addr_s;
	end

	// Internal initialisation runs on pclk, link clock not needed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			icnt_r <= '0;
		else if (!rst_n_s)
			icnt_r <= CNT_W'(INIT_WAIT_CYC_P);
		else if (icnt_r != '0)
			icnt_r <= icnt_r - 1'b1;
	end

	// Init and access state machine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= D_RESET;
			term_hiz <= 1'b1;
			ready <= 1'b0;
			cnt_r <= '0;
			open_banks <= '0;
			acc_valid <= 1'b0;
			acc_write <= 1'b0;
			acc_auto_pre <= 1'b0;
			acc_beats <= BL8_BEATS;
			acc_col <= '0;
			act_valid <= 1'b0;
			act_bank_group <= 1'b0;
			act_bank <= '0;
			act_row <= '0;
		end
		else if (!rst_n_s)
		begin
			state_r <= D_RESET;
			term_hiz <= 1'b1;
			ready <= 1'b0;
			open_banks <= '0;
			acc_valid <= 1'b0;
			act_valid <= 1'b0;
		end
		else
		begin
			acc_valid <= 1'b0;
			act_valid <= 1'b0;
			case (state_r)
				D_RESET:
					state_r <= D_PRE;
				D_PRE:
					if (ck_rise && cke_s)
					begin
						term_hiz <= 1'b0;
						state_r <= D_INIT;
					end
				D_INIT:
					if (cmd_take && cmd_s == CMD_ZQ && addr_s[AP_BIT])
					begin
						cnt_r <= CNT_W'(T_ZQDLL_CK);
						state_r <= D_ZQ;
					end
				D_ZQ:
					if (ck_rise)
					begin
						if (cnt_r > 1'b1)
							cnt_r <= cnt_r - 1'b1;
						else if (icnt_r == '0)
						begin
							ready <= 1'b1;
							open_banks <= '0;
							state_r <= D_READY;
						end
					end
				D_READY:
					if (cmd_take && !s[SW-6])
					begin
						act_valid <= 1'b1;
						act_bank_group <= bg_s;
						act_bank <= ba_s;
						act_row <= {cmd_s[0], addr_s};
						open_banks[bank_idx] <= 1'b1;
					end
					else if (cmd_take && is_rdwr && open_banks[bank_idx])
					begin
						acc_valid <= 1'b1;
						acc_write <= (cmd_s == CMD_WR);
						acc_auto_pre <= addr_s[AP_BIT];
						acc_beats <= beats;
						acc_col <= addr_s[COL_W-1:0];
						if (addr_s[AP_BIT])
							open_banks[bank_idx] <= 1'b0;
					end
				default:
					state_r <= D_RESET;
			endcase
		end
	end

	// Decoded defaults and termination state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			term_on <= 1'b0;
			gear_down_quarter <= 1'b0;
			pda_enable <= 1'b0;
			max_power_save <= 1'b0;
			cs_latency_on <= 1'b0;
			parity_latency_on <= 1'b0;
		end
		else
		begin
			term_on <= ~term_hiz & odt_s & (nominal_termination_setting != 3'h0);
			gear_down_quarter <= mr_r[3][MR3_GEARDOWN_BIT];
			pda_enable <= mr_r[3][MR3_PDA_BIT];
			max_power_save <= mr_r[4][MR4_MPS_BIT];
			cs_latency_on <= |mr_r[4][MR4_CAL_LSB +: 3];
			parity_latency_on <= |mr_r[5][MR5_PAR_LSB +: 3];
		end
	end
endmodule

// >>> tb/ddr4_init_sva.sv
// Link checker for the DDR4 reset and initialisation sequence
`timescale 1ns/1ps
module ddr4_init_sva import ddr4_init_pkg::*; #(
	parameter int INIT_WAIT = 40,
	parameter int RESET_MIN = 3
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_n,
	input wire logic cke,
	input wire logic odt,
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bg,
	input wire logic [1:0] ba,
	input wire logic [A_W-1:0] addr,
	input wire logic connectivity_test_enable
);
	logic cs_q_r;
	logic zq_seen_r;
	logic [2:0] mr_idx_r;
	logic [CNT_W-1:0] gap_r, cke_cnt_r, wait_r, low_r;
	// Command decode; a new command is the first slot with cs_n low
	wire [3:0] cmd = {act_n, ras_n, cas_n, we_n};
	wire cmd_new = cs_q_r & ~cs_n;
	wire is_mrs = cmd_new && (cmd == CMD_MRS);
	wire is_zq = cmd_new && (cmd == CMD_ZQ);
	// The low, CKE and gap counters saturate so long idle spells cannot wrap into a false failure; wait_r wraps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cs_q_r <= 1'b1;
			zq_seen_r <= 1'b0;
			mr_idx_r <= 3'h0;
			gap_r <= '0;
			cke_cnt_r <= '0;
			wait_r <= '0;
			low_r <= '0;
		end
		else
		begin
			cs_q_r <= cs_n;
			low_r <= reset_n ? '0 : ((&low_r) ? low_r : low_r + 1'b1);
			wait_r <= (!reset_n || cke) ? '0 : wait_r + 1'b1;
			cke_cnt_r <= !cke ? '0 : ((&cke_cnt_r) ? cke_cnt_r : cke_cnt_r + 1'b1);
			gap_r <= cmd_new ? '0 : ((&gap_r) ? gap_r : gap_r + 1'b1);
			mr_idx_r <= !reset_n ? 3'h0 : (is_mrs ? mr_idx_r + 3'h1 : mr_idx_r);
			zq_seen_r <= !reset_n ? 1'b0 : (is_zq | zq_seen_r);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_cte_low: assert property (connectivity_test_enable == 1'b0)
		else $error("test enable high");
	chk_cke_before_rel: assert property ($rose(reset_n) |-> !cke && $past(cke) == 1'b0)
		else $error("cke high at reset release");
	chk_reset_len: assert property ($rose(reset_n) |-> low_r >= RESET_MIN)
		else $error("reset pulse too short");
	chk_init_wait: assert property ($rose(cke) |-> reset_n && wait_r >= INIT_WAIT - 1)
		else $error("cke raised too early");
	chk_cke_stays: assert property ($fell(cke) |-> ##[0:2] !reset_n)
		else $error("cke dropped outside reset");
	chk_des_at_cke: assert property ($rose(cke) |-> cs_n)
		else $error("command at cke edge");
	chk_xpr_wait: assert property (is_mrs && mr_idx_r == 3'h0 |-> cke_cnt_r >= T_XPR_CK * 2 * CK_HALF - 2)
		else $error("first mode load too early");
	chk_mr_order: assert property (is_mrs |-> cke && {bg, ba} == MR_ORDER[mr_idx_r])
		else $error("mode load out of order");
	chk_cmd_slot: assert property (cmd_new |-> (!cs_n) [*8] ##1 cs_n)
		else $error("command slot length wrong");
	chk_mrd_gap: assert property (is_mrs && mr_idx_r != 3'h0 |-> gap_r >= T_MRD_CK * 2 * CK_HALF - 2)
		else $error("mode loads too close");
	chk_zq_after_mod: assert property (is_zq |-> mr_idx_r == 3'h7 && addr[AP_BIT]
		&& gap_r >= T_MOD_CK * 2 * CK_HALF - 2)
		else $error("calibration misplaced");
	chk_odt_static: assert property (!zq_seen_r |-> !odt)
		else $error("odt moved during init");
endmodule

// >>> tb/tb.sv
// Bench: both link ends joined, programmed over APB, cold and warm start
`timescale 1ns/1ps
module tb;
	import ddr4_init_pkg::*;
	localparam int COLD_P = 20;
	localparam int WAIT_P = 40;
	localparam int SEQ_P = (T_XPR_CK + 6 * T_MRD_CK + T_MOD_CK + T_ZQDLL_CK) * 2 * CK_HALF;
	// Mode values by register number; every defaulted field set in the cold run
	localparam logic [13:0] MRV [7] = '{14'h0001, 14'h0100, 14'h0000, 14'h0018, 14'h0042, 14'h0001, 14'h0000};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, init_done;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic term_hiz, term_on, ready, gq, pda, mps, csl, parl, acc_valid;
	logic [NUM_BANK-1:0] open_banks;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	ddr4_link_if link();
	ddr4_ctl_end #(.RESET_COLD_CYC_P(COLD_P), .INIT_WAIT_CYC_P(WAIT_P)) ddr4_ctl_end_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .init_done(init_done), .link(link));
	ddr4_dev_end #(.INIT_WAIT_CYC_P(WAIT_P)) ddr4_dev_end_i (.pclk(pclk), .presetn(presetn), .link(link),
		.term_hiz(term_hiz), .term_on(term_on), .ready(ready), .gear_down_quarter(gq), .pda_enable(pda),
		.max_power_save(mps), .cs_latency_on(csl), .parity_latency_on(parl), .acc_valid(acc_valid), .acc_write(),
		.acc_auto_pre(), .acc_beats(), .act_valid(), .act_bank_group(), .act_bank(), .act_row(), .acc_col(),
		.open_banks(open_banks));
	ddr4_init_sva #(.INIT_WAIT(WAIT_P), .RESET_MIN(RESET_WARM_CYC)) ddr4_init_sva_i (.pclk(pclk), .presetn(presetn),
		.reset_n(link.reset_n), .cke(link.cke), .odt(link.odt), .cs_n(link.cs_n), .act_n(link.act_n),
		.ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .bg(link.bg), .ba(link.ba), .addr(link.addr),
		.connectivity_test_enable(link.connectivity_test_enable));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		// Zero-wait slave: exactly one access cycle
		check(32'(n), 32'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(q & m, x);
		check(e, xe);
	endtask
	// Low spell of the link reset seen from just after the start write
	task automatic reset_len(output int n);
		n = 0;
		repeat (2) @(posedge pclk);
		while (link.reset_n !== 1'b1 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic wait_for(input int lim, input bit on_cke, output int n);
		n = 0;
		while ((on_cke ? link.cke : init_done) !== 1'b1 && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic t_regs();
		for (int i = 0; i < NUM_MR; i++)
			rd(REG_MR_BASE + 8'(4 * i), 32'hFFFFFFFF, 32'h0, 1'b0);
		rd(REG_STATUS, 32'h3, 32'h0, 1'b0);
		rd(8'h40, 32'hFFFFFFFF, 32'h0, 1'b1);
		check({gq, pda, mps, csl, parl}, 5'h00);
		for (int i = 0; i < NUM_MR; i++)
			wr(REG_MR_BASE + 8'(4 * i), {18'h0, MRV[i]});
		for (int i = 0; i < NUM_MR; i++)
			rd(REG_MR_BASE + 8'(4 * i), 32'h3FFF, {18'h0, MRV[i]}, 1'b0);
	endtask
	task automatic t_cold();
		int n;
		wr(REG_CTRL, 32'h1);
		reset_len(n);
		check(n + 2 >= COLD_P, 1'b1);
		check(term_hiz, 1'b1);
		wait_for(500, 1'b1, n);
		check(n >= WAIT_P - 2, 1'b1);
		check(term_hiz, 1'b1);
		rd(REG_STATUS, 32'h3, 32'h1, 1'b0);
		wait_for(20000, 1'b0, n);
		check(n >= SEQ_P - 16, 1'b1);
		// DRAM ready trails the controller by about 15 cycles of sync and edge finding
		repeat (24) @(posedge pclk);
		check({ready, term_hiz, term_on}, 3'h4);
		check({gq, pda, mps, csl, parl}, 5'h1F);
		check({acc_valid, open_banks}, 9'h000);
		rd(REG_STATUS, 32'h3, 32'h2, 1'b0);
	endtask
	task automatic t_odt();
		wr(REG_CTRL, 32'h4);
		repeat (12) @(posedge pclk);
		check({link.odt, term_on}, 2'h3);
	endtask
	task automatic t_warm();
		int n;
		wr(REG_MR_BASE + 8'h0C, 32'h0);
		wr(REG_CTRL, 32'h2);
		reset_len(n);
		check(n + 2 >= RESET_WARM_CYC && n < COLD_P - 4, 1'b1);
		check({term_hiz, init_done}, 2'h2);
		wr(REG_MR_BASE + 8'h0C, 32'h18);
		rd(REG_MR_BASE + 8'h0C, 32'h3FFF, 32'h0, 1'b0);
		wait_for(500, 1'b1, n);
		check({gq, pda, mps, csl, parl}, 5'h00);
		wait_for(20000, 1'b0, n);
		repeat (24) @(posedge pclk);
		check({ready, gq, pda, mps, csl, parl}, 6'h27);
	endtask
	// Free-running pclk
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			bad_count++;
			stop_test();
		end
	end
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_cold();
		t_odt();
		t_warm();
		stop_test();
	end
endmodule
